// >>> design/spk_pkg.sv
// Constants, types and helpers for the speaker amplifier control block
package spk_pkg;

  // ----------------------------------------------------------------
  // Bus shape
  // ----------------------------------------------------------------
  localparam int unsigned WB_ADR_W = 18;  // Byte address width
  localparam int unsigned WB_DAT_W = 32;  // Data width
  localparam int unsigned IDX_W    = 16;  // Register index width

  // ----------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_AMP_CTRL   = 16'hF2BC;
  localparam logic [IDX_W-1:0] IDX_WIRE_CTRL  = 16'hF2BF;
  localparam logic [IDX_W-1:0] IDX_SHORT_CTRL = 16'hF2C8;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 16'hF2C9;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK   = 16'hF2CA;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned AMP_EN_BIT    = 0;  // Output enable
  localparam int unsigned GAIN_BIT      = 1;  // Modulator gain
  localparam int unsigned WIRE_ON_BIT   = 0;  // Break detector on
  localparam int unsigned FLAG_BIT      = 7;  // Result flags
  localparam int unsigned SHORT_ON_BIT  = 0;  // Short detector on
  localparam int unsigned INTERVAL_LSB  = 1;  // Stuck-high code
  localparam int unsigned COUNT_LSB     = 4;  // Short count code
  localparam int unsigned IRQ_SHORT_BIT = 0;  // Short event
  localparam int unsigned IRQ_WIRE_BIT  = 1;  // Break event
  localparam logic [7:0]  REG_RESET     = 8'h00;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  typedef logic [2:0] code_t;
  localparam code_t CODE_CONST = 3'h0;  // Constant monitoring
  localparam code_t CODE_OFF   = 3'h7;  // Detection disabled

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned STUCK_BASE_NS   = 62_500;     // 62.5us
  localparam int unsigned GAIN1_BASE_NS   = 8_000_000;  // 8ms
  localparam int unsigned SHORT_SAMPLE_NS = 2_000;      // 2us
  localparam int unsigned STUCK_BASE_CYC  =
    (STUCK_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GAIN1_BASE_CYC  =
    (GAIN1_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SHORT_SAMPLE_CYC =
    (SHORT_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W  = 22;  // Stuck-high counter width
  localparam int unsigned TICK_W = 6;   // Sample divider width
  localparam int unsigned RUN_W  = 7;   // Consecutive hit counter

  // Word address matches a register index
  function automatic logic isReg(input logic [WB_ADR_W-1:0] adr,
                                 input logic [IDX_W-1:0] idx);
    isReg = (adr[WB_ADR_W-1:2] == idx);
  endfunction

endpackage

// >>> design/spk_short_det.sv
// Stuck-high PWM and speaker pin short judgment
`timescale 1ns/1ps
module spk_short_det #(
  parameter int unsigned STUCK_BASE_CYC = spk_pkg::STUCK_BASE_CYC,
  parameter int unsigned GAIN1_BASE_CYC = spk_pkg::GAIN1_BASE_CYC
) (
  input  wire logic          ref_clk,
  input  wire logic          reset_n,
  input  wire logic          clkEn,
  input  wire logic          detEn,
  input  wire logic          pwmLevel,
  input  wire logic          pinShort,
  input  wire logic          gainSel,
  input  wire spk_pkg::code_t intervalCode,
  input  wire spk_pkg::code_t countCode,
  output logic               detHit
);
  import spk_pkg::*;

  // ----------------------------------------------------------------
  // Stuck-high judgment
  // ----------------------------------------------------------------
  localparam logic [TICK_W-1:0] SAMPLE_LAST =
    TICK_W'(SHORT_SAMPLE_CYC - 1);

  // Judgment length in cycles for a gain and code
  function automatic logic [CNT_W-1:0] stuckLimit(input logic g,
                                                  input code_t c);
    logic [CNT_W-1:0] b1;
    b1 = CNT_W'(GAIN1_BASE_CYC);
    if (!g) begin
      stuckLimit = CNT_W'(STUCK_BASE_CYC) << c;
    end else begin
      unique case (c)
        3'h0:    stuckLimit = b1;
        3'h1:    stuckLimit = b1 + (b1 >> 1);
        3'h2:    stuckLimit = b1 << 1;
        3'h3:    stuckLimit = (b1 << 1) + b1;
        3'h4:    stuckLimit = b1 << 2;
        3'h5:    stuckLimit = (b1 << 2) + (b1 << 1);
        default: stuckLimit = b1 << 3;
      endcase
    end
  endfunction

  logic [CNT_W-1:0] highCntQ;   // Cycles PWM has stayed high
  logic             stuckHitQ;  // PWM judged stuck high
  logic [CNT_W-1:0] limitM1;    // Last count before judgment
  logic             stuckArm;   // Stuck-high judgment active

  assign limitM1  = stuckLimit(gainSel, intervalCode) - CNT_W'(1);
  assign stuckArm = detEn && (intervalCode != CODE_OFF);

  // time PWM high against chosen interval
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      highCntQ  <= '0;
      stuckHitQ <= 1'b0;
    end else if (clkEn) begin
      // PWM held high is an error
      if (!stuckArm || !pwmLevel) begin
        highCntQ  <= '0;
        stuckHitQ <= 1'b0;
      end else if (highCntQ == limitM1) begin
        stuckHitQ <= 1'b1;
      end else begin
        highCntQ <= highCntQ + CNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin short judgment
  // ----------------------------------------------------------------
  logic [TICK_W-1:0] tickCntQ;   // Sample period divider
  logic [RUN_W-1:0]  runQ;       // Consecutive short samples
  logic              shortHitQ;  // Pins judged shorted
  logic              shortArm;   // Short judgment active
  logic              tick;       // Sample instant
  logic [RUN_W-1:0]  need;       // Samples needed for judgment

  assign shortArm = detEn && (countCode != CODE_OFF);
  assign tick     = (tickCntQ == SAMPLE_LAST);
  assign need     = RUN_W'(1) << countCode;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      tickCntQ <= '0;
    end else if (clkEn) begin
      if (!shortArm || tick) begin
        tickCntQ <= '0;
      end else begin
        tickCntQ <= tickCntQ + TICK_W'(1);
      end
    end
  end

  // short between pins or to ground
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      runQ      <= '0;
      shortHitQ <= 1'b0;
    end else if (clkEn) begin
      if (!shortArm) begin
        runQ      <= '0;
        shortHitQ <= 1'b0;
      end else if (countCode == CODE_CONST) begin
        // Any single short counts
        shortHitQ <= pinShort;
      end else if (tick) begin
        if (!pinShort) begin
          runQ      <= '0;
          shortHitQ <= 1'b0;
        end else if (runQ + RUN_W'(1) >= need) begin
          shortHitQ <= 1'b1;
        end else begin
          runQ <= runQ + RUN_W'(1);
        end
      end
    end
  end

  assign detHit = stuckHitQ | shortHitQ;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_stuck_off: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (intervalCode == CODE_OFF) && clkEn |=> !stuckHitQ)
    else $error("stuck-high hit with detection disabled");

  a_stuck_fire: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    stuckArm && pwmLevel && clkEn && (highCntQ == limitM1)
    |=> stuckHitQ)
    else $error("stuck-high not judged at interval end");

  a_short_const: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    shortArm && (countCode == CODE_CONST) && pinShort && clkEn
    |=> shortHitQ)
    else $error("constant monitoring missed a short");

  a_short_sample: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(shortHitQ) && ($past(countCode) != CODE_CONST) |-> $past(tick))
    else $error("counted short judged off a sample instant");

endmodule

// >>> design/spk_amp_ctrl.sv
// Speaker amplifier control, detectors and Wishbone registers
`timescale 1ns/1ps
module spk_amp_ctrl #(
  parameter int unsigned STUCK_BASE_CYC = spk_pkg::STUCK_BASE_CYC,
  parameter int unsigned GAIN1_BASE_CYC = spk_pkg::GAIN1_BASE_CYC
) (
  input  wire logic                         ref_clk,
  input  wire logic                         reset_n,
  input  wire logic                         clkEn,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [spk_pkg::WB_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [spk_pkg::WB_DAT_W-1:0] wb_dat_i,
  output logic      [spk_pkg::WB_DAT_W-1:0] wb_dat_o,
  output logic                              wb_ack_o,
  input  wire logic                         playbackEnableBit,
  input  wire logic                         pwmLevel,
  input  wire logic                         shortSenseIn,
  input  wire logic                         wireSenseIn,
  output logic                              speakerOutPositive,
  output logic                              speakerOutPositiveOe,
  output logic                              speakerOutNegative,
  output logic                              speakerOutNegativeOe,
  output logic                              modulatorGainSelect,
  output logic                              wireBreakDetectorOn,
  output logic                              playbackStopBit,
  output logic                              pwmReset,
  output logic                              irq
);
  import spk_pkg::*;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic       ackQ;        // Acknowledge, one cycle per request
  logic       accept;      // Request taken this cycle
  logic       wrLane;      // Write with low byte lane
  logic       wrAmp;       // Write to amp control
  logic       wrWire;      // Write to wire break control
  logic       wrShort;     // Write to short control
  logic       wrMask;      // Write to interrupt mask
  logic       rdStatus;    // Read of interrupt status
  logic [7:0] wByte;       // Written byte

  assign accept   = wb_cyc_i && wb_stb_i && !ackQ;
  assign wrLane   = accept && wb_we_i && wb_sel_i[0];
  assign wByte    = wb_dat_i[7:0];
  assign wrAmp    = wrLane && isReg(wb_adr_i, IDX_AMP_CTRL);
  assign wrWire   = wrLane && isReg(wb_adr_i, IDX_WIRE_CTRL);
  assign wrShort  = wrLane && isReg(wb_adr_i, IDX_SHORT_CTRL);
  assign wrMask   = wrLane && isReg(wb_adr_i, IDX_IRQ_MASK);
  assign rdStatus = accept && !wb_we_i
                    && isReg(wb_adr_i, IDX_IRQ_STATUS);

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] syncAQ;      // First stage, read by second only
  logic [1:0] syncBQ;      // Second stage
  logic [1:0] syncCQ;      // Third stage
  logic [1:0] senseQ;      // Accepted levels {wire, short}

  // Three-stage capture of the analog comparators
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      syncAQ <= 2'h0;
      syncBQ <= 2'h0;
      syncCQ <= 2'h0;
    end else if (clkEn) begin
      syncAQ <= {wireSenseIn, shortSenseIn};
      syncBQ <= syncAQ;
      syncCQ <= syncBQ;
    end
  end

  // Level changes once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      senseQ <= 2'h0;
    end else if (clkEn) begin
      for (int i = 0; i < 2; i++) begin
        if (syncBQ[i] == syncCQ[i]) begin
          senseQ[i] <= syncCQ[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [1:0] ampCtrlQ;    // Gain select and output enable
  logic       wireOnQ;     // Wire break detector on
  logic [6:0] shortCtrlQ;  // Count, interval and detector on
  logic [1:0] irqMaskQ;    // Interrupt mask

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ampCtrlQ   <= REG_RESET[1:0];
      wireOnQ    <= REG_RESET[WIRE_ON_BIT];
      shortCtrlQ <= REG_RESET[6:0];
      irqMaskQ   <= REG_RESET[1:0];
    end else if (clkEn) begin
      if (wrAmp) begin
        ampCtrlQ <= wByte[1:0];
      end
      if (wrWire) begin
        wireOnQ <= wByte[WIRE_ON_BIT];
      end
      if (wrShort) begin
        shortCtrlQ <= wByte[6:0];
      end
      if (wrMask) begin
        irqMaskQ <= wByte[1:0];
      end
    end
  end

  logic  ampOn;            // Amplifier driving pins
  logic  shortOn;          // Short detector enable bit
  logic  shortEn;          // Short detection effective
  code_t intervalCode;     // Stuck-high interval code
  code_t countCode;        // Short count code

  assign ampOn        = ampCtrlQ[AMP_EN_BIT];
  assign shortOn      = shortCtrlQ[SHORT_ON_BIT];
  assign intervalCode = shortCtrlQ[INTERVAL_LSB +: 3];
  assign countCode    = shortCtrlQ[COUNT_LSB +: 3];
  assign shortEn      = shortOn && ampOn && playbackEnableBit;

  // ----------------------------------------------------------------
  // Short and stuck-high detection
  // ----------------------------------------------------------------
  logic detHit;            // Judgment from the detector

  spk_short_det #(
    .STUCK_BASE_CYC (STUCK_BASE_CYC),
    .GAIN1_BASE_CYC (GAIN1_BASE_CYC)
  ) u_det (
    .ref_clk      (ref_clk),
    .reset_n      (reset_n),
    .clkEn        (clkEn),
    .detEn        (shortEn),
    .pwmLevel     (pwmLevel),
    .pinShort     (senseQ[0]),
    .gainSel      (ampCtrlQ[GAIN_BIT]),
    .intervalCode (intervalCode),
    .countCode    (countCode),
    .detHit       (detHit)
  );

  logic shortFlagQ;        // Short result flag
  logic stopQ;             // Stop and PWM reset pulse
  logic shortEvent;        // First judgment of a short

  assign shortEvent = detHit && !shortFlagQ;

  // flag holds until detector bit cleared
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      shortFlagQ <= 1'b0;
      stopQ      <= 1'b0;
    end else if (clkEn) begin
      if (detHit) begin
        // New judgment wins over clearing
        shortFlagQ <= 1'b1;
      end else if (!shortOn) begin
        shortFlagQ <= 1'b0;
      end
      // stop playback on the first judgment
      stopQ <= shortEvent;
    end
  end

  assign playbackStopBit = stopQ;
  assign pwmReset        = stopQ;

  // ----------------------------------------------------------------
  // Wire break detection
  // ----------------------------------------------------------------
  logic wireFlagQ;         // Wire break result flag

  // result follows the comparator while on
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      wireFlagQ <= 1'b0;
    end else if (clkEn) begin
      wireFlagQ <= wireOnQ && senseQ[1];
    end
  end

  assign wireBreakDetectorOn = wireOnQ;

  // ----------------------------------------------------------------
  // Speaker pins
  // ----------------------------------------------------------------
  logic posQ;              // Positive pin level
  logic negQ;              // Negative pin level

  // Both low after a short so no current flows
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      posQ <= 1'b0;
      negQ <= 1'b0;
    end else if (clkEn) begin
      posQ <= ampOn && !shortFlagQ && pwmLevel;
      negQ <= ampOn && !shortFlagQ && !pwmLevel;
    end
  end

  assign speakerOutPositiveOe = ampOn;
  assign speakerOutNegativeOe = ampOn;
  assign speakerOutPositive   = posQ;
  assign speakerOutNegative   = negQ;
  assign modulatorGainSelect  = ampCtrlQ[GAIN_BIT];

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [1:0] irqStatusQ;  // Sticky events
  logic [1:0] irqSet;      // Events this cycle
  logic       wireEvent;   // Break flag rising

  assign wireEvent = wireOnQ && senseQ[1] && !wireFlagQ;
  assign irqSet    = {wireEvent, shortEvent};

  // short raises its interrupt; set wins over read clear
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      irqStatusQ <= 2'h0;
    end else if (clkEn) begin
      if (rdStatus) begin
        irqStatusQ <= irqSet;
      end else begin
        irqStatusQ <= irqStatusQ | irqSet;
      end
    end
  end

  assign irq = |(irqStatusQ & irqMaskQ);

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  logic [WB_DAT_W-1:0] rdataQ;  // Registered read data
  logic [7:0]          rByte;   // Selected register byte

  // Read mux, unmapped reads zero
  always_comb begin
    rByte = 8'h00;
    if (isReg(wb_adr_i, IDX_AMP_CTRL)) begin
      rByte = {6'h00, ampCtrlQ};
    end else if (isReg(wb_adr_i, IDX_WIRE_CTRL)) begin
      rByte = {wireFlagQ, 6'h00, wireOnQ};
    end else if (isReg(wb_adr_i, IDX_SHORT_CTRL)) begin
      rByte = {shortFlagQ, shortCtrlQ};
    end else if (isReg(wb_adr_i, IDX_IRQ_STATUS)) begin
      rByte = {6'h00, irqStatusQ};
    end else if (isReg(wb_adr_i, IDX_IRQ_MASK)) begin
      rByte = {6'h00, irqMaskQ};
    end
  end

  // One-cycle acknowledge for any address
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ackQ   <= 1'b0;
      rdataQ <= '0;
    end else if (clkEn) begin
      ackQ <= accept;
      if (accept && !wb_we_i) begin
        rdataQ <= {24'h00_0000, rByte};
      end
    end
  end

  assign wb_ack_o = ackQ;
  assign wb_dat_o = rdataQ;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_detect;
    $rose(shortFlagQ);
  endsequence

  a_pins_float: assert property (
    wrAmp && clkEn && !wByte[AMP_EN_BIT]
    |=> !speakerOutPositiveOe && !speakerOutNegativeOe)
    else $error("pins still driven after disable");

  a_gain_follow: assert property (
    wrAmp && clkEn |=> modulatorGainSelect == $past(wByte[GAIN_BIT]))
    else $error("gain select did not follow write");

  a_wire_enable: assert property (
    wrWire && clkEn |=> wireBreakDetectorOn == $past(wByte[0]))
    else $error("break detector enable did not follow write");

  a_wire_flag_off: assert property (
    !wireOnQ && clkEn |=> !wireFlagQ)
    else $error("break flag set with detector off");

  a_short_gate: assert property (
    !shortEn && clkEn |=> !detHit)
    else $error("detection outside enabled playback");

  a_stop_on_hit: assert property (
    s_detect |-> playbackStopBit && pwmReset ##1 !playbackStopBit)
    else $error("playback not stopped on detection");

  a_irq_short: assert property (
    s_detect |-> irqStatusQ[IRQ_SHORT_BIT]
                 && (irq || !irqMaskQ[IRQ_SHORT_BIT]))
    else $error("short interrupt not raised");

  a_flag_hold: assert property (
    shortFlagQ && shortOn && clkEn |=> shortFlagQ)
    else $error("short flag dropped while detector on");

  a_reset_zero: assert property (
    @(posedge ref_clk) disable iff (1'b0)
    !reset_n |=> ampCtrlQ == 2'h0 && shortCtrlQ == 7'h00
                 && !wireOnQ && !shortFlagQ && !speakerOutPositiveOe)
    else $error("registers not cleared by reset");

endmodule

// >>> verif/spk_load.sv
// Speaker wiring model on the far side of the amplifier pins
`timescale 1ns/1ps
module spk_load (
  input  wire logic posOe,      // Positive pin driven
  input  wire logic negOe,      // Negative pin driven
  input  wire logic shortCmd,   // Bench asks for a shorted load
  input  wire logic openCmd,    // Bench asks for a broken wire
  output logic      shortSense, // Short comparator level
  output logic      wireSense   // Break comparator level
);
  // short seen only on driven pins
  assign shortSense = shortCmd & posOe & negOe;
  // break level follows the wiring state
  assign wireSense = openCmd;
endmodule

// >>> verif/test_spk_amp_ctrl.sv
// Register-level regression of the speaker amplifier control block
`timescale 1ns/1ps
module test_spk_amp_ctrl;
  import spk_pkg::*;
  logic ref_clk = 0, reset_n = 0, cyc = 0, we = 0, ack, irq, stop;
  logic [17:0] adr = '0;
  logic [31:0] dat = '0, datO;
  logic play = 0, pwm = 0, shortCmd = 0, openCmd = 0;
  logic sS, wS, pOe, nOe, pos, neg, pwr, gain, wOn;
  logic [7:0] q;
  logic [23:0] hi;
  int errorCnt = 0, checksDone = 0, stopCnt = 0, cycN = 0, rstCnt = 0;

  // Clock and watchdog
  initial forever #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    stopCnt <= stopCnt + int'(stop === 1'b1);
    rstCnt <= rstCnt + int'(pwr === 1'b1);
    cycN <= cycN + 1;
    if (cycN == 30000) begin
      errorCnt++;
      printVerdict();
    end
  end

  spk_amp_ctrl #(.STUCK_BASE_CYC(4), .GAIN1_BASE_CYC(16)) dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .clkEn(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
    .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack),
    .playbackEnableBit(play), .pwmLevel(pwm), .shortSenseIn(sS),
    .wireSenseIn(wS), .speakerOutPositive(pos),
    .speakerOutPositiveOe(pOe), .speakerOutNegative(neg),
    .speakerOutNegativeOe(nOe), .modulatorGainSelect(gain),
    .wireBreakDetectorOn(wOn), .playbackStopBit(stop), .pwmReset(pwr),
    .irq(irq));
  spk_load load (.posOe(pOe), .negOe(nOe), .shortCmd(shortCmd),
    .openCmd(openCmd), .shortSense(sS), .wireSense(wS));

  // Classic single Wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [15:0] i, input logic [7:0] d);
    @(posedge ref_clk);
    cyc <= 1;
    we <= w;
    adr <= {i, 2'b00};
    dat <= {24'h0, d};
    do @(posedge ref_clk); while (ack !== 1'b1);
    q = datO[7:0];
    hi = datO[31:8];
    cyc <= 0;
  endtask

  // Compare one byte
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checksDone++;
    if (g !== e) begin
      errorCnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic printVerdict();
    $display("checks %0d mismatches %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    reset_n <= 1;
    // Reset values and unmapped place
    wb(0, IDX_AMP_CTRL, 0);
    chk("amp", 8'h00, q);
    wb(0, IDX_WIRE_CTRL, 0);
    chk("wire", 8'h00, q);
    wb(0, IDX_SHORT_CTRL, 0);
    chk("short", 8'h00, q);
    chk("upper", 8'h00, {7'h00, |hi});
    chk("oe", 8'h00, {pOe, nOe});
    wb(0, 16'h0010, 0);
    chk("unmapped", 8'h00, q);
    $display("test reset done");
    // Amp enable and gain, PWM low drives the negative pin
    wb(1, IDX_AMP_CTRL, 8'hFF);
    wb(0, IDX_AMP_CTRL, 0);
    chk("amp rb", 8'h03, q);
    chk("oe on", 8'h03, {pOe, nOe});
    chk("pins on", 8'h01, {pos, neg});
    chk("gain", 8'h01, gain);
    wb(1, IDX_AMP_CTRL, 8'h00);
    chk("oe off", 8'h00, {pOe, nOe});
    $display("test amp done");
    // Wire break, read after the settle time with amp off
    wb(1, IDX_IRQ_MASK, 8'h03);
    openCmd <= 1;
    wb(1, IDX_WIRE_CTRL, 8'h01);
    chk("wOn", 8'h01, wOn);
    repeat (20000) @(posedge ref_clk);
    wb(0, IDX_WIRE_CTRL, 0);
    chk("break", 8'h81, q);
    chk("irq w", 8'h01, irq);
    wb(0, IDX_IRQ_STATUS, 0);
    chk("st w", 8'h02, q);
    chk("irq clr", 8'h00, irq);
    wb(1, IDX_WIRE_CTRL, 8'h00);
    chk("wOff", 8'h00, wOn);
    $display("test wire done");
    // Pin short, stuck-high masked by interval code 7
    pwm <= 1;
    play <= 1;
    wb(1, IDX_AMP_CTRL, 8'h01);
    wb(1, IDX_SHORT_CTRL, 8'h0F);
    repeat (60) @(posedge ref_clk);
    chk("no stop", 8'h00, stopCnt[7:0]);
    shortCmd <= 1;
    wait (stopCnt == 1);
    @(posedge ref_clk);
    chk("irq s", 8'h01, irq);
    chk("pins", 8'h00, pos);
    wb(0, IDX_SHORT_CTRL, 0);
    chk("sflag", 8'h8F, q);
    wb(0, IDX_IRQ_STATUS, 0);
    chk("st s", 8'h01, q);
    shortCmd <= 0;
    wb(1, IDX_SHORT_CTRL, 8'h0E);
    wb(0, IDX_SHORT_CTRL, 0);
    chk("sclr", 8'h0E, q);
    $display("test short done");
    // Stuck-high only while playback enabled
    play <= 0;
    wb(1, IDX_SHORT_CTRL, 8'h71);
    repeat (60) @(posedge ref_clk);
    chk("idle", 8'h01, stopCnt[7:0]);
    play <= 1;
    wait (stopCnt == 2);
    wb(0, IDX_SHORT_CTRL, 0);
    chk("stuck", 8'hF1, q);
    $display("test stuck done");
    // Count code 1 needs two shorted samples 2us apart
    pwm <= 0;
    shortCmd <= 1;
    wb(1, IDX_SHORT_CTRL, 8'h00);
    wb(1, IDX_SHORT_CTRL, 8'h1F);
    repeat (50) @(posedge ref_clk);
    chk("one hit", 8'h02, stopCnt[7:0]);
    wait (stopCnt == 3);
    wb(0, IDX_SHORT_CTRL, 0);
    chk("counted", 8'h9F, q);
    $display("test count done");
    // Gain one, code 1: judgment after one and a half base units
    shortCmd <= 0;
    wb(1, IDX_SHORT_CTRL, 8'h00);
    wb(1, IDX_AMP_CTRL, 8'h03);
    pwm <= 1;
    wb(1, IDX_SHORT_CTRL, 8'h73);
    repeat (18) @(posedge ref_clk);
    chk("gain1 early", 8'h03, stopCnt[7:0]);
    repeat (12) @(posedge ref_clk);
    chk("gain1 hit", 8'h04, stopCnt[7:0]);
    chk("pwm reset", 8'h04, rstCnt[7:0]);
    $display("test gain done");
    printVerdict();
  end
endmodule
